// ---- rtl/pin_sync.sv ----
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] pins_i,
  input  wire logic [WIDTH-1:0] reset_val_i,
  output logic      [WIDTH-1:0] synced_o
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_synced;

  // First stage feeds only the second stage
  always_comb begin
    next_stage1 = ce_i ? pins_i : stage1;
    next_synced = ce_i ? stage1 : synced_o;
  end

  // Reset values are constants at the instance
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      stage1   <= reset_val_i;
      synced_o <= reset_val_i;
    end else begin
      stage1   <= next_stage1;
      synced_o <= next_synced;
    end
  end
endmodule : pin_sync
`default_nettype wire

// ---- rtl/rate_spi_pkg.sv ----
// Constants shared by the rate-sensor serial slave port
package rate_spi_pkg;
  localparam int          FRAME_BITS     = 16;
  localparam int          CNT_W          = 5;
  localparam int          ADDR_W         = 7;
  localparam int          DATA_W         = 16;
  localparam int          REG_WORDS      = 64;
  // Frame field positions
  localparam int          WR_FLAG_BIT    = 15;
  localparam int          ADDR_MSB       = 14;
  localparam int          ADDR_LSB       = 8;
  localparam int          BYTE_MSB       = 7;
  // Reset values
  localparam logic [15:0] TX_RESET       = 16'h0000;
  localparam logic [15:0] TICK_RESET     = 16'h0000;
  // Autonomous sample period, in core clocks
  localparam int          SAMPLE_PERIOD  = 64;
  // Stall time between frames the master must keep, for reference
  localparam int          STALL_NORMAL_US = 9;
  localparam int          STALL_LOWPWR_US = 12;
endpackage : rate_spi_pkg

// ---- rtl/rate_spi_slave.sv ----
// Serial slave port of the rate sensor, with a small autonomous register core
// What this block does
// - The port runs clock idle high, sampling on rising and shifting on falling edges.
// - Chip select is active low and traffic is honoured only while it is low.
// - The first output bit appears when chip select falls, before any clock edge.
// - Later output bits change only after a falling serial clock edge.
// - Input bits are captured on rising serial clock edges.
// - With chip select high the serial output is released to high impedance.
// - The core updates its one sample word (word 2) continuously without any command.
// - A read uses two frames: command and address first, the data in the next frame.
// - A write frame carries one byte and acts right after the sixteenth rising edge.
// - A 7-bit address picks a 16-bit word, either byte address selecting it for a read.
`timescale 1ns/1ps
`default_nettype none
module rate_spi_slave
  import rate_spi_pkg::*;
#(
  parameter int PERIOD = SAMPLE_PERIOD
) (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic sclk_i,
  input  wire logic cs_n_i,
  input  wire logic sdi_i,
  output logic      sdo_o,
  output logic      sdo_oe_o,
  output logic      frame_done_o,
  output logic      write_strobe_o
);
  typedef enum logic [1:0] {
    IDLE  = 2'b00,
    SHIFT = 2'b01,
    DONE  = 2'b10
  } port_state_t;

  logic [2:0] synced;
  logic       sclk_s;
  logic       cs_n_s;
  logic       sdi_s;

  // Pins come from the master's domain; two flops before use
  pin_sync #(.WIDTH(3)) u_sync (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .pins_i      ({sclk_i, cs_n_i, sdi_i}),
    .reset_val_i (3'h6),
    .synced_o    (synced)
  );
  assign sclk_s = synced[2];
  assign cs_n_s = synced[1];
  assign sdi_s  = synced[0];

  // Word index from a byte address: both byte addresses hit one word
  function automatic logic [5:0] word_index(input logic [ADDR_W-1:0] a);
    word_index = a[ADDR_W-1:1];
  endfunction

  port_state_t         state;
  port_state_t         next_state;
  logic                sclk_q;
  logic                cs_n_q;
  logic [DATA_W-1:0]   rx;
  logic [DATA_W-1:0]   next_rx;
  logic [DATA_W-1:0]   tx;
  logic [DATA_W-1:0]   next_tx;
  logic [CNT_W-1:0]    bits;
  logic [CNT_W-1:0]    next_bits;
  logic [DATA_W-1:0]   pending;
  logic [DATA_W-1:0]   next_pending;
  logic                next_sdo;
  logic                next_sdo_oe;
  logic                next_done;
  logic                next_wstb;
  logic [DATA_W-1:0]   regs [REG_WORDS];
  logic [DATA_W-1:0]   tick;
  logic [DATA_W-1:0]   next_tick;
  logic [7:0]          period_cnt;
  logic [7:0]          next_period_cnt;
  logic                do_write;
  logic [5:0]          wr_idx;
  logic                wr_hi;
  logic [7:0]          wr_byte;

  // Edge flops reset to the pins' idle levels, so no false edge follows reset.
  // Edges are seen two or three core clocks late; the link clock must stay at
  // each level for several core clocks or an edge is lost.
  wire rise    = sclk_s & ~sclk_q;
  wire fall    = ~sclk_s & sclk_q;
  wire cs_fall = ~cs_n_s & cs_n_q;

  // The first clock fall of a frame shifts nothing: the top bit was launched by
  // the select edge and must still stand at the first rise. A frame cut short by
  // select rising leaves pending alone, so the next frame returns the same word.
  // Frame engine: load on select, shift on clock edges
  always_comb begin
    next_state   = state;
    next_rx      = rx;
    next_tx      = tx;
    next_bits    = bits;
    next_pending = pending;
    next_sdo     = sdo_o;
    next_sdo_oe  = ~cs_n_s;
    next_done    = 1'b0;
    next_wstb    = 1'b0;
    do_write     = 1'b0;
    case (state)
      IDLE: begin
        if (cs_fall) begin
          next_tx    = pending;
          next_sdo   = pending[DATA_W-1];
          next_bits  = '0;
          next_state = SHIFT;
        end
      end
      SHIFT: begin
        if (cs_n_s) begin
          next_state = IDLE;        // Short frame is dropped
        end else if (rise) begin
          next_rx   = {rx[DATA_W-2:0], sdi_s};
          next_bits = bits + 5'h01;
          if (bits == 5'(FRAME_BITS - 1)) begin
            next_state = DONE;
            next_done  = 1'b1;
            if (next_rx[WR_FLAG_BIT]) begin
              do_write  = 1'b1;
              next_wstb = 1'b1;
            end
            next_pending = regs[word_index(next_rx[ADDR_MSB:ADDR_LSB])];
          end
        end else if (fall && bits != 5'h00) begin
          next_tx  = {tx[DATA_W-2:0], 1'b0};
          next_sdo = tx[DATA_W-2];
        end
      end
      DONE: begin
        if (cs_n_s) begin
          next_state = IDLE;
        end
      end
      default: next_state = IDLE;
    endcase
  end

  // Registers only; next values come from the frame engine above, the edge flops from the synced pins.
  // Clock enable low holds the whole port, pin synchroniser included.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state          <= IDLE;
      sclk_q         <= 1'b1;
      cs_n_q         <= 1'b1;
      rx             <= '0;
      tx             <= TX_RESET;
      bits           <= '0;
      pending        <= TX_RESET;
      sdo_o          <= 1'b0;
      sdo_oe_o       <= 1'b0;
      frame_done_o   <= 1'b0;
      write_strobe_o <= 1'b0;
    end else if (ce_i) begin
      state          <= next_state;
      sclk_q         <= sclk_s;
      cs_n_q         <= cs_n_s;
      rx             <= next_rx;
      tx             <= next_tx;
      bits           <= next_bits;
      pending        <= next_pending;
      sdo_o          <= next_sdo;
      sdo_oe_o       <= next_sdo_oe;
      frame_done_o   <= next_done;
      write_strobe_o <= next_wstb;
    end
  end

  // Autonomous core: a running sample word refreshed every period
  // The 8-bit period counter limits PERIOD to 256 core clocks; it stands still
  // with the rest of the block while the clock enable is low.
  always_comb begin
    next_period_cnt = period_cnt + 8'h01;
    next_tick       = tick;
    if (period_cnt == 8'(PERIOD - 1)) begin
      next_period_cnt = 8'h00;
      next_tick       = tick + 16'h0001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      period_cnt <= 8'h00;
      tick       <= TICK_RESET;
    end else if (ce_i) begin
      period_cnt <= next_period_cnt;
      tick       <= next_tick;
    end
  end

  // Word that mirrors the running sample counter; writes aimed at it are dropped
  localparam logic [5:0] TICK_WORD = 6'h02;

  // Byte write into the word store; word 2 mirrors the sample counter
  assign wr_idx  = word_index(next_rx[ADDR_MSB:ADDR_LSB]);
  assign wr_hi   = next_rx[ADDR_LSB];
  assign wr_byte = next_rx[BYTE_MSB:0];

  // Memory holds no reset; contents are undefined until written.
  // Pending is read at the same edge that a write lands, so a write frame
  // hands back the addressed word as it stood before the write.
  always_ff @(posedge core_clk_i) begin
    if (ce_i) begin
      regs[TICK_WORD] <= tick;
      if (do_write && wr_idx != TICK_WORD) begin
        if (wr_hi) begin
          regs[wr_idx][15:8] <= wr_byte;
        end else begin
          regs[wr_idx][7:0] <= wr_byte;
        end
      end
    end
  end
endmodule : rate_spi_slave
`default_nettype wire

// ---- verif/rate_spi_slave_properties.sv ----
// Pin timing checker for the rate-sensor serial slave port
`timescale 1ns/1ps
`default_nettype none
module rate_spi_slave_properties #(
  parameter int PERIOD = 64
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_o,
  input wire logic frame_done_o,
  input wire logic write_strobe_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Windows allow for the two sync flops and the edge detector
  a_hiz_when_idle: assert property (cs_n_i [*6] |-> !sdo_oe_o) else $error("sdo driven while deselected");
  a_drive_in_frame: assert property (!cs_n_i [*6] |-> sdo_oe_o) else $error("sdo not driven in frame");
  a_oe_after_select: assert property ($rose(sdo_oe_o) |-> !$past(cs_n_i, 2)) else $error("sdo driven early");
  a_msb_before_clk: assert property ($rose(sdo_oe_o) |-> sclk_i) else $error("first bit late");
  a_shift_after_fall: assert property ($changed(sdo_o) && sdo_oe_o && $past(sdo_oe_o, 2) |->
    !$past(sclk_i, 3) || !$past(sclk_i, 4)) else $error("sdo moved without clock fall");
  a_done_after_rise: assert property (frame_done_o |-> $past(sclk_i, 3) && !cs_n_i) else $error("done misplaced");
  a_done_one_cycle: assert property (frame_done_o |=> !frame_done_o) else $error("done too long");
  a_strobe_with_done: assert property (write_strobe_o |-> frame_done_o) else $error("lone strobe");
  a_no_done_idle: assert property (cs_n_i [*8] |-> !frame_done_o) else $error("done while idle");
  cover property (write_strobe_o);
  cover property (frame_done_o && !write_strobe_o);
  cover property ($fell(sdo_oe_o));
endmodule // rate_spi_slave_properties
bind rate_spi_slave rate_spi_slave_properties #(.PERIOD(PERIOD)) chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .sdi_i(sdi_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
  .frame_done_o(frame_done_o), .write_strobe_o(write_strobe_o));
`default_nettype wire

// ---- verif/rate_spi_slave_tb.sv ----
// Self-checking bench for the rate-sensor serial slave port
`timescale 1ns/1ps
`default_nettype none
module rate_spi_slave_tb;
  logic        core_clk_i = 1'b0;
  logic        rst_i      = 1'b1;
  logic        ce         = 1'b1;
  // Sample period given to the core, and one full frame with its stall in core clocks
  localparam int          TB_PERIOD   = 16;
  localparam int          FRAME_CLKS  = 369;
  localparam int          FREEZE_CLKS = 160;
  localparam logic [15:0] STEP_LO     = 16'(FRAME_CLKS / TB_PERIOD);
  logic        sclk, cs_n, sdi, sdo, sdo_oe, done, wstb;
  wire         sdo_line   = sdo_oe ? sdo : 1'bz; // Released pin floats
  int          num_errors = 0, cmp_count = 0, n_done = 0, n_wr = 0, cycles = 0;
  logic [15:0] rx, v1;
  always #20 core_clk_i = ~core_clk_i;
  rate_spi_slave #(.PERIOD(TB_PERIOD)) uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce), .sclk_i(sclk),
    .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .frame_done_o(done), .write_strobe_o(wstb));
  spi_master_model m (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo_line));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Pulse counters and hang guard, sampled mid-cycle so registered pulses have settled
  always @(negedge core_clk_i) begin
    cycles++;
    if (done === 1'b1) n_done++;
    if (wstb === 1'b1) n_wr++;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  // Both bytes written, then read back through each byte address
  task automatic t_write_read;
    int d0, d1;
    d0 = n_wr;
    d1 = n_done;
    m.xfer(16'ha1a5, 16, rx);
    m.xfer(16'ha03c, 16, rx);
    check("write strobes", 16'(n_wr - d0), 16'h0002);
    check("write frames", 16'(n_done - d1), 16'h0002);
    m.xfer(16'h2100, 16, rx);
    m.xfer(16'h2000, 16, rx);
    check("read upper", rx, 16'ha53c);
    check("msb early", 16'(m.msb_early), 16'h0001);
    m.xfer(16'h1100, 16, rx);
    check("read lower", rx, 16'ha53c);
    check("released", 16'(sdo_oe), 16'h0000);
  endtask
  // Select lifted mid-frame: no frame, nothing written
  task automatic t_abort;
    int d0;
    d0 = n_done;
    m.xfer(16'ha1ff, 8, rx);
    check("abort frames", 16'(n_done - d0), 16'h0000);
    m.xfer(16'h2000, 16, rx);
    m.xfer(16'h0400, 16, rx);
    check("word kept", rx, 16'ha53c);
  endtask
  // Free-running word moves between reads with no command
  task automatic t_autonomous;
    m.xfer(16'h0500, 16, rx);
    m.xfer(16'h0400, 16, v1);
    m.xfer(16'h0000, 16, rx);
    check("counter moved", 16'(v1 != rx), 16'h0001);
    check("counter step", 16'((rx - v1) inside {STEP_LO, STEP_LO + 16'h0001}), 16'h0001);
  endtask
  // Clock enable low freezes the core: the step over one frame ignores the frozen stretch
  task automatic t_freeze;
    m.xfer(16'h0400, 16, rx);
    ce = 1'b0;
    repeat (FREEZE_CLKS) @(negedge core_clk_i);
    ce = 1'b1;
    m.xfer(16'h0400, 16, v1);
    m.xfer(16'h0000, 16, rx);
    check("frozen step", 16'((rx - v1) inside {STEP_LO, STEP_LO + 16'h0001}), 16'h0001);
  endtask
  initial begin
    repeat (5) @(negedge core_clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    check("idle", 16'(sdo_oe), 16'h0000);
    t_write_read();
    t_abort();
    t_autonomous();
    t_freeze();
    end_sim();
  end
endmodule // rate_spi_slave_tb
`default_nettype wire

// ---- verif/spi_master_model.sv ----
// Behavioural SPI master facing the slave port
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  logic msb_early;
  // Idle high clock
  initial begin
    sclk_o    = 1'b1;
    cs_n_o    = 1'b1;
    sdi_o     = 1'b1;
    msb_early = 1'b0;
  end
  // One frame per select, MSB first; fewer than 16 bits aborts it
  // Called on a falling core clock edge; pin moves are whole core clocks apart (only the sample is not), so pins move there too
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'hxxxx;
    cs_n_o = 1'b0;
    #320 msb_early = sdo_i; // Top bit must stand before the first clock edge
    for (int i = 15; i > 15 - nbits; i--) begin
      sclk_o = 1'b0;
      sdi_o  = tx[i]; // Held across the rise
      #160 sclk_o = 1'b1;
      #150 rx[i] = sdo_i; // Late sample, the port answers a few core clocks after the fall
      #10;
    end
    #320 cs_n_o = 1'b1;
    sdi_o = ~sdi_o; // Released line shows no stale bit
    #9000; // Stall gap
  endtask
endmodule // spi_master_model
`default_nettype wire
